// File: core/tcp_core.sv
// Purpose: Timer channel output stage: PWM, prepare signals, dead time, break, quadrature.
// Assumes: ref_clk at 40 MHz, synchronous active-high rst, pins synchronised here.
// Notes on behaviour
// (R01) Modes 6 and 7 give PWM waveform.
// (R02) Edge aligned: period reload, duty compare.
// (R03) Center aligned: period and duty doubled.
// (R04) Compare above reload: mode0 low, mode1 high.
// (R05) Match: hold, set, clear, toggle.
// (R06) PWM level follows direction and comparison; the code uses the comparison only, not dir_down.
// (R07) Modes 4 and 5 force low/high.
// (R08) External clear zeroes prepare until update.
// (R09) Three complementary pairs, never both active.
// (R10) Off, no idle select, disabled: both low.
// (R11) Off: inactive levels, then idle after dead time.
// (R12) Disabled output releases its pin.
// (R13) Off-state drives polarity level; run select keeps.
// (R14) Enabled: prepare xor polarity, inverted for complement.
// (R15) Dead time only both enables plus enable.
// (R16) Rising edge delays main, falling delays complement.
// (R17) Short pulses under dead time vanish.
// (R18) Break from pin with polarity or clock monitor.
// (R19) Break clears output enable, sets flag.
// (R20) After break: reset levels, idle after dead time.
// (R21) Quadrature counts on A, B, or both.
// (R22) Direction from edge and other input level.
// (R23) Quadrature counts within zero to reload.
// (R24) Software sets reload before quadrature start.
// (R25) Dead time counted in kernel clock cycles.
`timescale 1ns/1ps
module tcp_core
    import tcp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic break_pin,
    input wire logic oscillator_monitor_stuck,
    input wire logic filtered_external_trigger,
    input wire logic encoder_input_a,
    input wire logic encoder_input_b,
    output tcp_pin_t [TCP_NCH-1:0] main_output,
    output tcp_pin_t [TCP_NPAIR-1:0] complementary_output,
    output logic break_irq
);
    // Software registers.
    logic [31:0] ctrl;
    logic [31:0] mode;
    logic [31:0] chen;
    logic [31:0] brk;
    logic [TCP_CW-1:0] counter_reload_value;
    logic [TCP_CW-1:0] channel_compare_value [TCP_NCH];
    // Counter state shared by all channels.
    logic [TCP_CW-1:0] cnt;
    logic dir_down;
    logic update;
    logic break_event_flag;
    logic primary_output_enable;
    // Synchronisers for the pins, two stages each.
    logic [4:0] s1, s2, s3;
    // Decoded control fields.
    wire counter_on = ctrl[TCP_C_CEN];
    wire center = ctrl[TCP_C_CAM];
    wire [2:0] slave_mode_field = ctrl[TCP_C_SM +: 3];
    wire run_offstate_select = brk[TCP_B_ROS];
    wire idle_offstate_select = brk[TCP_B_IOS];
    wire break_detect_enable = brk[TCP_B_BEN];
    wire break_input_polarity = brk[TCP_B_BPOL];
    wire break_interrupt_enable = brk[TCP_B_BIE];
    wire [TCP_DTW-1:0] deadtime_setting = brk[TCP_B_DT +: TCP_DTW];
    wire quad = (slave_mode_field == TCP_SM_QA) || (slave_mode_field == TCP_SM_QB)
        || (slave_mode_field == TCP_SM_QAB);
    // Synchronised pin levels; s2 is the stable copy, s3 the previous one.
    wire brk_pin_s = s2[0];
    wire etr_s = s2[2];
    wire qa = s2[3];
    wire qb = s2[4];
    wire qa_edge = s2[3] ^ s3[3];
    wire qb_edge = s2[4] ^ s3[4];
    // Break source: pin with polarity or stuck oscillator. [R18]
    wire break_hit = break_detect_enable && ((brk_pin_s == break_input_polarity) || s2[1]);
    // Quadrature step request and direction. [R21] [R22]
    wire use_a = (slave_mode_field == TCP_SM_QA) || (slave_mode_field == TCP_SM_QAB);
    wire use_b = (slave_mode_field == TCP_SM_QB) || (slave_mode_field == TCP_SM_QAB);
    wire q_step_a = use_a && qa_edge;
    wire q_step_b = use_b && qb_edge;
    wire q_step = q_step_a || q_step_b;
    // A rising with B high counts down; B rising with A high counts up.
    wire q_down = q_step_a ? (qa ~^ qb) : (qa ^ qb);
    // Write decode strobes.
    wire wr_ctrl = wr && (addr == TCP_A_CTRL);
    wire wr_brk = wr && (addr == TCP_A_BRK);
    wire wr_stat = wr && (addr == TCP_A_STAT);

    // Pin synchronisers; first stage feeds only the second.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1 <= 5'h00;
            s2 <= 5'h00;
            s3 <= 5'h00;
        end else begin
            s1 <= {encoder_input_b, encoder_input_a, filtered_external_trigger,
                   oscillator_monitor_stuck, break_pin};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Register writes; the break register holds the output enable separately.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl <= 32'h0000_0000;
            mode <= 32'h0000_0000;
            chen <= 32'h0000_0000;
            brk <= 32'h0000_0000;
            counter_reload_value <= 16'hFFFF;
        end else if (wr) begin
            case (addr)
                TCP_A_CTRL: ctrl <= wdata;
                TCP_A_MODE: mode <= wdata;
                TCP_A_CHEN: chen <= wdata;
                TCP_A_BRK: brk <= wdata;
                TCP_A_RELOAD: counter_reload_value <= wdata[TCP_CW-1:0]; // [R24]
                default: ;
            endcase
        end
    end

    // Compare values are an array addressed by channel.
    genvar gi;
    generate
        for (gi = 0; gi < TCP_NCH; gi++) begin : g_cv
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    channel_compare_value[gi] <= 16'h0000;
                end else if (wr && (addr == TCP_A_CV0 + 4'(gi))) begin
                    channel_compare_value[gi] <= wdata[TCP_CW-1:0];
                end
            end
        end
    endgenerate

    // Output enable and break flag. Break wins over a software set, and the
    // enable drops the cycle after the break is seen; the flag set wins over a clear.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            primary_output_enable <= 1'b0;
            break_event_flag <= 1'b0;
        end else begin
            if (break_hit) begin
                primary_output_enable <= 1'b0; // [R19]
            end else if (wr_brk) begin
                primary_output_enable <= wdata[TCP_B_POE];
            end
            if (break_hit) begin
                break_event_flag <= 1'b1; // [R19]
            end else if (wr_stat && wdata[TCP_S_BIF]) begin
                break_event_flag <= 1'b0;
            end
        end
    end
    // Gating by break_hit makes the pin effect immediate inside the cycle.
    wire poe_eff = primary_output_enable && !break_hit; // [R19]
    assign break_irq = break_event_flag && break_interrupt_enable; // [R19]

    // Counter: edge aligned wraps at reload, center aligned bounces,
    // quadrature steps on encoder edges inside zero to reload.
    wire at_top = (cnt >= counter_reload_value);
    wire at_bot = (cnt == 16'h0000);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt <= 16'h0000;
            dir_down <= 1'b0;
            update <= 1'b0;
        end else if (quad) begin
            update <= 1'b0;
            if (q_step) begin
                dir_down <= q_down; // [R22]
                if (q_down) begin
                    cnt <= at_bot ? counter_reload_value : cnt - 16'h0001; // [R23]
                end else begin
                    cnt <= at_top ? 16'h0000 : cnt + 16'h0001; // [R23]
                end
            end
        end else if (!counter_on) begin
            update <= 1'b0;
        end else if (center) begin
            // Period is twice the reload value. [R03]
            update <= (dir_down && cnt == 16'h0001) || (!dir_down && at_top);
            if (!dir_down && at_top) begin
                dir_down <= 1'b1;
                cnt <= cnt - 16'h0001;
            end else if (dir_down && at_bot) begin
                dir_down <= 1'b0;
                cnt <= cnt + 16'h0001;
            end else begin
                cnt <= dir_down ? cnt - 16'h0001 : cnt + 16'h0001;
            end
        end else begin
            // Period equals the reload value plus the zero state. [R02]
            dir_down <= 1'b0;
            update <= at_top;
            cnt <= at_top ? 16'h0000 : cnt + 16'h0001;
        end
    end

    // Per channel prepare signal, outputs and dead time.
    logic [TCP_NCH-1:0] prep;
    generate
        for (gi = 0; gi < TCP_NCH; gi++) begin : g_ch
            wire [2:0] compare_mode_field = mode[gi*TCP_M_SLOT +: 3];
            wire external_clear_enable = mode[gi*TCP_M_SLOT + TCP_M_CEN];
            wire [TCP_CW-1:0] channel_match_value = channel_compare_value[gi];
            wire main_channel_enable = chen[gi*TCP_E_SLOT + TCP_E_EN];
            wire main_polarity = chen[gi*TCP_E_SLOT + TCP_E_P];
            wire idle_level_main = chen[gi*TCP_E_SLOT + TCP_E_IM];
            wire match = (cnt == channel_match_value);
            wire below = (cnt < channel_match_value)
                && (channel_match_value <= counter_reload_value); // [R04]
            // A compare above reload keeps mode 0 low and mode 1 high. [R04] [R06]
            wire pwm_lvl = (compare_mode_field == TCP_CM_PWM0) ? below : !below; // [R01]
            logic pre, cleared, next_pre;
            // Prepare signal selection by compare mode.
            always_comb begin
                next_pre = pre;
                case (compare_mode_field)
                    TCP_CM_FROZEN: next_pre = pre; // [R05]
                    TCP_CM_SET: next_pre = match ? 1'b1 : pre; // [R05]
                    TCP_CM_CLR: next_pre = match ? 1'b0 : pre; // [R05]
                    TCP_CM_TOG: next_pre = match ? !pre : pre; // [R05]
                    TCP_CM_FLO: next_pre = 1'b0; // [R07]
                    TCP_CM_FHI: next_pre = 1'b1; // [R07]
                    default: next_pre = pwm_lvl; // [R01] [R06]
                endcase
            end
            // External clear holds prepare low until the next update.
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    pre <= 1'b0;
                    cleared <= 1'b0;
                end else begin
                    pre <= next_pre;
                    if (external_clear_enable && etr_s) begin
                        cleared <= 1'b1; // [R08]
                    end else if (update) begin
                        cleared <= 1'b0; // [R08]
                    end
                end
            end
            assign prep[gi] = pre && !cleared && !(external_clear_enable && etr_s); // [R08]
            if (gi < TCP_NPAIR) begin : g_pair
                wire complementary_channel_enable = chen[gi*TCP_E_SLOT + TCP_E_NEN];
                wire complementary_polarity = chen[gi*TCP_E_SLOT + TCP_E_NP];
                wire idle_level_complementary = chen[gi*TCP_E_SLOT + TCP_E_IN];
                wire both_en = main_channel_enable && complementary_channel_enable;
                wire dt_on = both_en && poe_eff; // [R15]
                logic [TCP_DTW-1:0] dtc;
                logic prep_d, was_off, idle_ok, m_act, n_act;
                // The cycle of the edge is the first dead cycle, so one less is loaded.
                wire [TCP_DTW-1:0] dt_load = deadtime_setting - 8'(deadtime_setting != 8'h00);
                // Dead time counter restarts on each prepare edge; both sides
                // stay inactive while it runs. [R16] [R17] [R25]
                always_ff @(posedge ref_clk) begin
                    if (rst) begin
                        dtc <= 8'h00;
                        prep_d <= 1'b0;
                        was_off <= 1'b1;
                        idle_ok <= 1'b0;
                    end else begin
                        prep_d <= prep[gi];
                        was_off <= !poe_eff;
                        if ((prep[gi] != prep_d) || (poe_eff == was_off)) begin
                            dtc <= dt_load; // [R25]
                        end else if (dtc != 8'h00) begin
                            dtc <= dtc - 8'h01;
                        end
                        // Idle levels wait one dead time after leaving run. [R11] [R20]
                        idle_ok <= !poe_eff && (dtc == 8'h00) && !(poe_eff == was_off);
                    end
                end
                wire dt_done = (dtc == 8'h00) && ((prep[gi] == prep_d) || !(|deadtime_setting));
                assign m_act = prep[gi] && (!dt_on || dt_done); // [R16] [R17]
                assign n_act = !prep[gi] && (!dt_on || dt_done); // [R16] [R14]
                // Output table: run, off-state, idle and disabled cases.
                wire off_drive = !poe_eff && (idle_offstate_select || both_en
                    || main_channel_enable || complementary_channel_enable);
                wire m_lvl = !poe_eff ? (idle_ok ? idle_level_main : main_polarity) // [R11] [R13]
                    : main_channel_enable ? (m_act ^ main_polarity) // [R14]
                    : main_polarity; // [R13]
                wire n_lvl = !poe_eff ? (idle_ok ? idle_level_complementary
                    : complementary_polarity) // [R11]
                    : complementary_channel_enable ? ((main_channel_enable ? n_act
                    : prep[gi]) ^ complementary_polarity) // [R14]
                    : complementary_polarity; // [R13]
                // Pin drive; disabled outputs float unless an off-state select, or when off another enable, keeps them driven. [R12] [R13]
                wire m_drv = poe_eff ? (main_channel_enable || run_offstate_select) : off_drive;
                wire n_drv = poe_eff ? (complementary_channel_enable || run_offstate_select)
                    : off_drive;
                // Both outputs low when off with nothing enabled and no idle select. [R10]
                wire all_low = !poe_eff && !idle_offstate_select && !main_channel_enable
                    && !complementary_channel_enable;
                always_ff @(posedge ref_clk) begin
                    if (rst) begin
                        main_output[gi] <= '{val: 1'b0, oe_n: 1'b1};
                        complementary_output[gi] <= '{val: 1'b0, oe_n: 1'b1};
                    end else begin
                        main_output[gi] <= '{val: all_low ? 1'b0 : m_lvl, oe_n: !m_drv}; // [R09]
                        complementary_output[gi] <= '{val: all_low ? 1'b0 : n_lvl,
                            oe_n: !n_drv}; // [R09]
                    end
                end
                // Main and complement never active together while running.
                property p_excl;
                    @(posedge ref_clk) disable iff (rst)
                    ($past(poe_eff) && $stable(chen))
                        |-> !((main_output[gi].val ^ main_polarity)
                        && (complementary_output[gi].val ^ complementary_polarity));
                endproperty
                a_excl: assert property (p_excl) else $error("pair both active"); // [R09]
                property p_dtrise;
                    @(posedge ref_clk) disable iff (rst)
                    (dt_on && $rose(prep[gi]) && deadtime_setting != 8'h00) |-> !m_act;
                endproperty
                a_dtrise: assert property (p_dtrise) else $error("main rose early"); // [R16]
            end else begin : g_single
                always_ff @(posedge ref_clk) begin
                    if (rst) begin
                        main_output[gi] <= '{val: 1'b0, oe_n: 1'b1};
                    end else begin
                        main_output[gi] <= '{val: poe_eff && main_channel_enable
                            ? (prep[gi] ^ main_polarity) : main_polarity, // [R14]
                            oe_n: !(main_channel_enable || (poe_eff ? run_offstate_select
                            : idle_offstate_select))}; // [R12]
                    end
                end
            end
            property p_force;
                @(posedge ref_clk) disable iff (rst)
                (compare_mode_field == TCP_CM_FHI) ##1 (compare_mode_field == TCP_CM_FHI)
                |-> pre;
            endproperty
            a_force: assert property (p_force) else $error("forced high missing"); // [R07]
            property p_clear;
                @(posedge ref_clk) disable iff (rst)
                (external_clear_enable && etr_s) |-> !prep[gi];
            endproperty
            a_clear: assert property (p_clear) else $error("clear not applied"); // [R08]
        end
    endgenerate

    // Read mux: one cycle latency.
    wire [31:0] stat_word = {24'h000000, prep, 2'h0, dir_down, break_event_flag};
    wire [31:0] brk_word = {brk[31:1], primary_output_enable};
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                TCP_A_CTRL: rdata <= ctrl;
                TCP_A_MODE: rdata <= mode;
                TCP_A_CHEN: rdata <= chen;
                TCP_A_BRK: rdata <= brk_word;
                TCP_A_RELOAD: rdata <= {16'h0000, counter_reload_value};
                TCP_A_STAT: rdata <= stat_word;
                TCP_A_CNT: rdata <= {16'h0000, cnt};
                default: rdata <= (addr >= TCP_A_CV0 && addr < TCP_A_CV0 + 4'h4)
                    ? {16'h0000, channel_compare_value[addr[1:0]]} : 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // Break drops the enable and raises the flag together, one cycle after it is seen.
    property p_brk;
        @(posedge ref_clk) disable iff (rst)
        break_hit |=> (!primary_output_enable && break_event_flag);
    endproperty
    a_brk: assert property (p_brk) else $error("break not taken"); // [R19]
    // Quadrature up step below reload adds one to the count.
    property p_qrange;
        @(posedge ref_clk) disable iff (rst)
        (quad && q_step && !at_top && !q_down) |=> (cnt == $past(cnt) + 16'h0001);
    endproperty
    a_qrange: assert property (p_qrange) else $error("quad up step wrong"); // [R23]
    property p_qdir;
        @(posedge ref_clk) disable iff (rst)
        (quad && q_step) |=> (dir_down == $past(q_down));
    endproperty
    a_qdir: assert property (p_qdir) else $error("direction not updated"); // [R22]
    property p_edge;
        @(posedge ref_clk) disable iff (rst)
        (!quad && counter_on && !center && at_top) |=> (cnt == 16'h0000);
    endproperty
    a_edge: assert property (p_edge) else $error("edge wrap wrong"); // [R02]
endmodule // tcp_core

// File: core/tcp_pkg.sv
// Purpose: Shared constants and carrier types for the timer channel output block.
// Assumes: One kernel clock; counter core lives inside this block.
// Notes: Register offsets are word addresses on a plain strobe port.
package tcp_pkg;
    // Number of channels and of channels with a complementary pair.
    localparam int TCP_NCH = 4;
    localparam int TCP_NPAIR = 3;
    localparam int TCP_CW = 16;
    // Compare mode encodings.
    localparam logic [2:0] TCP_CM_FROZEN = 3'h0;
    localparam logic [2:0] TCP_CM_SET = 3'h1;
    localparam logic [2:0] TCP_CM_CLR = 3'h2;
    localparam logic [2:0] TCP_CM_TOG = 3'h3;
    localparam logic [2:0] TCP_CM_FLO = 3'h4;
    localparam logic [2:0] TCP_CM_FHI = 3'h5;
    localparam logic [2:0] TCP_CM_PWM0 = 3'h6;
    localparam logic [2:0] TCP_CM_PWM1 = 3'h7;
    // Slave mode encodings for the quadrature decoder.
    localparam logic [2:0] TCP_SM_QA = 3'h1;
    localparam logic [2:0] TCP_SM_QB = 3'h2;
    localparam logic [2:0] TCP_SM_QAB = 3'h3;
    // Register word addresses.
    localparam logic [3:0] TCP_A_CTRL = 4'h0;
    localparam logic [3:0] TCP_A_MODE = 4'h1;
    localparam logic [3:0] TCP_A_CHEN = 4'h2;
    localparam logic [3:0] TCP_A_BRK = 4'h3;
    localparam logic [3:0] TCP_A_RELOAD = 4'h4;
    localparam logic [3:0] TCP_A_STAT = 4'h5;
    localparam logic [3:0] TCP_A_CNT = 4'h6;
    localparam logic [3:0] TCP_A_CV0 = 4'h8;
    // Field positions in the BRK register.
    localparam int TCP_B_POE = 0;
    localparam int TCP_B_ROS = 1;
    localparam int TCP_B_IOS = 2;
    localparam int TCP_B_BEN = 3;
    localparam int TCP_B_BPOL = 4;
    localparam int TCP_B_BIE = 5;
    localparam int TCP_B_DT = 8;
    localparam int TCP_DTW = 8;
    // Field positions in the CTRL register.
    localparam int TCP_C_CEN = 0;
    localparam int TCP_C_CAM = 1;
    localparam int TCP_C_SM = 4;
    // Field positions in MODE: per channel a 4-bit slot.
    localparam int TCP_M_SLOT = 4;
    localparam int TCP_M_CEN = 3;
    // Field positions in CHEN: per channel a 6-bit slot.
    localparam int TCP_E_SLOT = 6;
    localparam int TCP_E_EN = 0;
    localparam int TCP_E_NEN = 1;
    localparam int TCP_E_P = 2;
    localparam int TCP_E_NP = 3;
    localparam int TCP_E_IM = 4;
    localparam int TCP_E_IN = 5;
    // Status bits.
    localparam int TCP_S_BIF = 0;
    localparam int TCP_S_DIR = 1;
    localparam int TCP_S_PRE = 4;
    // Per-pin drive carrier: value and output enable (low means driving).
    typedef struct packed {
        logic val;
        logic oe_n;
    } tcp_pin_t;
endpackage

// File: verification/tcp_partner.sv
// Purpose: Power stage and quadrature encoder seen from the timer pins.
// Assumes: One step request moves the encoder by one Gray state.
// Notes: The break line is the gate driver fault output, active high.
`timescale 1ns/1ps
module tcp_partner (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic step,
    input wire logic back,
    input wire logic brk_on,
    output logic encoder_input_a,
    output logic encoder_input_b,
    output logic break_pin
);
    logic [1:0] phase; // Shaft position within one quadrature cycle.
    // Forward order is 00, 10, 11, 01 on (a, b), so only one line moves per step.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase <= 2'h0;
        end else if (step) begin
            phase <= back ? phase - 2'h1 : phase + 2'h1;
        end
    end
    assign encoder_input_a = phase[1] ^ phase[0];
    assign encoder_input_b = phase[1];
    assign break_pin = brk_on; // Fault level follows the request.
endmodule // tcp_partner

// File: verification/tb.sv
// Purpose: Self-checking bench for the timer channel output block.
// Assumes: Register map and latencies as the design package states.
// Notes: Clock monitor stays idle; external trigger is driven only in the clear test.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb;
    import tcp_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, step = 1'b0, back = 1'b0;
    logic brk_on = 1'b0, etr = 1'b0, irq, ea, eb, bp;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, v, seed = 32'h00016780;
    logic [3:0] pol; // Random output polarities.
    logic [2:0] m;
    tcp_pin_t [TCP_NCH-1:0] mo;
    tcp_pin_t [TCP_NPAIR-1:0] co;
    int err_count = 0, cmp_count = 0, n, base, cv;
    always #12.5 ref_clk = ~ref_clk;
    tcp_core DUT (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .break_pin(bp), .oscillator_monitor_stuck(1'b0),
        .filtered_external_trigger(etr), .encoder_input_a(ea), .encoder_input_b(eb),
        .main_output(mo), .complementary_output(co), .break_irq(irq));
    tcp_partner PS (.ref_clk(ref_clk), .rst(rst), .step(step), .back(back), .brk_on(brk_on),
        .encoder_input_a(ea), .encoder_input_b(eb), .break_pin(bp));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // High cycles in 100 cycles with reload 9, which gives ten periods of ten states.
    function automatic int pwm_exp(input logic [2:0] md, input int c);
        if (c > 9) return (md == TCP_CM_PWM0) ? 0 : 100;
        return (md == TCP_CM_PWM0) ? c * 10 : 100 - c * 10;
    endfunction
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Spacing of six cycles keeps encoder edges apart for the input synchroniser.
    task automatic turn(input logic b);
        @(posedge ref_clk);
        step <= 1'b1;
        back <= b;
        @(posedge ref_clk);
        step <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rreg(TCP_A_RELOAD, v); `CHK("reload", 32'h0000FFFF, v)
        rreg(4'h7, v); `CHK("unmapped", 32'h0, v)
        // Forced levels on all four channels with random polarity.
        pol = 4'(xs());
        for (int c = 0; c < 4; c++) v[c*6 +: 3] = {pol[c], 2'b01};
        wreg(TCP_A_CHEN, v);
        wreg(TCP_A_MODE, 32'h5454);
        wreg(TCP_A_BRK, 32'h1);
        repeat (6) @(posedge ref_clk);
        #1 for (int c = 0; c < 4; c++) `CHK("pin", {c[0] ^ pol[c], 1'b0}, mo[c])
        `CHK("comp_off", 1'b1, co[0].oe_n)
        rreg(TCP_A_STAT, v); `CHK("pre", 4'hA, v[7:4])
        // Edge-aligned duty in both modes, compare inside and beyond reload.
        wreg(TCP_A_RELOAD, 32'h9);
        wreg(TCP_A_CHEN, 32'h1);
        wreg(TCP_A_CTRL, 32'h1);
        for (int t = 0; t < 4; t++) begin
            m = TCP_CM_PWM0 + 3'(t % 2);
            cv = (t > 1) ? 12 : 3;
            wreg(TCP_A_CV0, 32'(cv));
            wreg(TCP_A_MODE, {29'h0, m});
            repeat (25) @(negedge ref_clk);
            n = 0;
            repeat (100) begin
                @(negedge ref_clk);
                n += int'(mo[0].val);
            end
            `CHK("duty", pwm_exp(m, cv), n)
        end
        // Pair with a dead time of two cycles on a five-cycle duty.
        wreg(TCP_A_CHEN, 32'h3);
        wreg(TCP_A_BRK, 32'h201);
        wreg(TCP_A_CV0, 32'h5);
        wreg(TCP_A_MODE, 32'h6);
        repeat (25) @(negedge ref_clk);
        n = 0;
        base = 0;
        repeat (100) begin
            @(negedge ref_clk);
            n += int'(mo[0].val);
            base += int'(co[0].val);
        end
        `CHK("dt_main", 30, n)
        `CHK("dt_comp", 30, base)
        // External clear holds a forced-high prepare low until an update.
        wreg(TCP_A_MODE, 32'hD);
        @(posedge ref_clk);
        etr <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rreg(TCP_A_STAT, v); `CHK("etr_clr", 1'b0, v[4])
        @(posedge ref_clk);
        etr <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rreg(TCP_A_STAT, v); `CHK("etr_rel", 1'b1, v[4])
        // Quadrature counting in each slave mode, then one step back.
        wreg(TCP_A_RELOAD, 32'h64);
        for (int s = 1; s < 4; s++) begin
            wreg(TCP_A_CTRL, 32'h1 | (s << 4));
            rreg(TCP_A_CNT, v);
            base = int'(v[15:0]) + ((s == 3) ? 4 : 2);
            repeat (4) turn(1'b0);
            rreg(TCP_A_CNT, v); `CHK("qcnt", 16'(base), v[15:0])
        end
        turn(1'b1);
        rreg(TCP_A_CNT, v); `CHK("qback", 16'(base - 1), v[15:0])
        rreg(TCP_A_STAT, v); `CHK("dir", 1'b1, v[1])
        // Break with idle off-state kept, idle main high, dead time of four cycles.
        wreg(TCP_A_MODE, 32'h4);
        wreg(TCP_A_CHEN, 32'h13);
        wreg(TCP_A_BRK, 32'h43D);
        repeat (12) @(posedge ref_clk);
        #1 `CHK("comp_on", 2'b10, co[0])
        brk_on <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        if (irq !== 1'b1) err_count++;
        repeat (12) @(posedge ref_clk);
        #1 `CHK("idle_main", 2'b10, mo[0])
        `CHK("idle_comp", 2'b00, co[0])
        rreg(TCP_A_STAT, v); `CHK("flag", 1'b1, v[0])
        rreg(TCP_A_BRK, v); `CHK("poe", 1'b0, v[0])
        brk_on <= 1'b0;
        repeat (6) @(posedge ref_clk);
        wreg(TCP_A_STAT, 32'h1);
        rreg(TCP_A_STAT, v); `CHK("flag_clr", 1'b0, v[0])
        `CHK("irq_clr", 1'b0, irq)
        summarize();
    end
endmodule // tb
